// file: rtl/drgc_defines.svh
// Offsets, field positions, reset values and timing counts of the ramp core
`ifndef DRGC_DEFINES_SVH
`define DRGC_DEFINES_SVH

// Register offsets (word index on the internal write port)
`define DRGC_OFS_CW1      8'h00
`define DRGC_OFS_CW2      8'h01
`define DRGC_OFS_RISE     8'h06
`define DRGC_OFS_FALL     8'h07
`define DRGC_OFS_RATE     8'h0C
`define DRGC_OFS_LIM_LO   8'h0D
`define DRGC_OFS_LIM_HI   8'h0E

// Field positions in control word one
`define DRGC_B_RELOAD     15
`define DRGC_B_ACLR       14
`define DRGC_B_CLR        12
// Field positions in control word two
`define DRGC_B_DST_HI     21
`define DRGC_B_DST_LO     20
`define DRGC_B_EN         19
`define DRGC_B_NDH        18
`define DRGC_B_NDL        17
`define DRGC_B_FLEN       13
// Field positions in the rate register
`define DRGC_RATE_P_LO    0
`define DRGC_RATE_N_LO    16

// Reset values
`define DRGC_RST_WORD     32'h0000_0000
`define DRGC_RST_TIMER    16'h0000

// DDS clock is the system clock divided by this ratio
`define DRGC_DDS_DIV      5'h18
`define DRGC_DDS_LAST     5'h17

`endif

// file: rtl/drgc_pkg.sv
// Types shared by the ramp generator core
package drgc_pkg;

   // One register write from the host side
   typedef struct packed {
      logic        wr;     // Write strobe, one cycle
      logic [7:0]  addr;   // Register offset
      logic [31:0] data;   // Write data
   } drgc_wr_t;

   // Active control bits after an update
   typedef struct packed {
      logic       en;      // Ramp enable
      logic       ndh;     // No-dwell high
      logic       ndl;     // No-dwell low
      logic [1:0] dest;    // Destination select
      logic       flen;    // Limit flag output enable
      logic       reload;  // Reload timer at update
      logic       clr;     // Clear accumulator
      logic       aclr;    // Auto-clear accumulator
   } drgc_ctrl_t;

   // Destination encodings
   typedef enum logic [1:0] {
      DRGC_DST_FREQ  = 2'h0,
      DRGC_DST_PHASE = 2'h1
   } drgc_dest_t;

endpackage : drgc_pkg

// file: rtl/drgc_core.sv
// Digital ramp generator core: accumulator, interval timer, limits
`timescale 1ns/1ns
`include "drgc_defines.svh"

// Overview of operation
// - 32-bit accumulator paced by DDS-clock interval timer
// - Rise interval P, fall interval N, 16 bits
// - Rise and fall step registers at 0x06, 0x07
// - Fall step is subtracted while falling
// - Phase keeps top 16, amplitude top 12
// - Timer reloads on enable, direction edge, expiry, update with reload bit set
// - Output held between lower and upper limit
// - Clear forces output to lower limit
// - Normal behaviour only with no-dwell bits clear
// - Enable acts at update; low direction loads lower
// - Rise stops at upper, resumes if raised
// - Fall stops at lower, resumes if lowered
// - Freeze pin stalls accumulator and output
// - Clear bit acts and releases only at update
// - Auto-clear holds accumulator one DDS cycle
// - Enable bit gates all ramp logic
// - Destination field routes output MSB aligned
// - Limit flag high at either limit if enabled
// - No-dwell bits at 0x01[18:17]
module drgc_core (
   input  wire logic               ref_clk_i,
   input  wire logic               rstn_i,
   input  wire drgc_pkg::drgc_wr_t cfg_wr_i,
   input  wire logic               io_update_i,
   input  wire logic               ramp_direction_pin_i,
   input  wire logic               ramp_freeze_pin_i,
   output logic [31:0]             ramp_word_o,
   output logic [31:0]             dest_word_o,
   output logic [1:0]              dest_sel_o,
   output logic                    ramp_limit_flag_pin_o,
   output logic                    normal_mode_o
);

   logic                    rst_meta_r;  // Reset synchroniser stage one
   logic                    rst_n;       // Released reset copy
   logic                    dir_meta_r;  // Direction pin stage one
   logic                    dir_s_r;     // Direction pin synchronised
   logic                    dir_d_r;     // Direction seen at last tick
   logic                    hold_meta_r; // Freeze pin stage one
   logic                    hold_s_r;    // Freeze pin synchronised
   logic [4:0]              div_r;       // DDS clock divider
   logic                    tick_r;      // One DDS clock cycle
   logic [31:0]             cw1_r;       // Shadow control word one
   logic [31:0]             cw2_r;       // Shadow control word two
   logic [31:0]             rise_r;      // Shadow rise step
   logic [31:0]             fall_r;      // Shadow fall step
   logic [31:0]             rate_r;      // Shadow interval rate
   logic [63:0]             lim_r;       // Shadow limit pair
   drgc_pkg::drgc_ctrl_t    ctl_a_r;     // Active control bits
   drgc_pkg::drgc_ctrl_t    ctl_nxt;     // Control decoded from shadow
   logic [31:0]             rise_a_r;    // Active rise step
   logic [31:0]             fall_a_r;    // Active fall step
   logic [31:0]             rate_a_r;    // Active interval rate
   logic [63:0]             lim_a_r;     // Active limit pair
   logic                    ev_en_r;     // Enable rise pending
   logic                    ev_aclr_r;   // Auto-clear pending
   logic                    ev_rld_r;    // Reload at update pending
   logic [15:0]             timer_r;     // Interval timer
   logic [31:0]             acc_r;       // Ramp accumulator
   logic [31:0]             lower;       // Lower limit
   logic [31:0]             upper;       // Upper limit
   logic                    dir_edge;    // Direction change at tick
   logic                    expire;      // Timer expiry at tick
   logic                    force_low;   // Accumulator forced to lower
   logic                    normal;      // Both no-dwell bits clear
   logic [32:0]             sum_up;      // Rising candidate
   logic [32:0]             sum_dn;      // Falling candidate

   // All checks run on the system clock, off during reset
   default clocking ramp_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n);

   // Reset release through two flip-flops
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Pin synchronisers, stage one read only by stage two
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dir_meta_r  <= 1'b0;
         dir_s_r     <= 1'b0;
         hold_meta_r <= 1'b0;
         hold_s_r    <= 1'b0;
      end else begin
         dir_meta_r  <= ramp_direction_pin_i;
         dir_s_r     <= dir_meta_r;
         hold_meta_r <= ramp_freeze_pin_i;
         hold_s_r    <= hold_meta_r;
      end
   end

   // DDS clock tick: one cycle in twenty-four
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         div_r  <= 5'h00;
         tick_r <= 1'b0;
      end else if (div_r == `DRGC_DDS_LAST) begin
         div_r  <= 5'h00;
         tick_r <= 1'b1;
      end else begin
         div_r  <= div_r + 5'h01;
         tick_r <= 1'b0;
      end
   end

   // Shadow registers written by the host
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cw1_r  <= `DRGC_RST_WORD;
         cw2_r  <= `DRGC_RST_WORD;
         rise_r <= `DRGC_RST_WORD;
         fall_r <= `DRGC_RST_WORD;
         rate_r <= `DRGC_RST_WORD;
         lim_r  <= {`DRGC_RST_WORD, `DRGC_RST_WORD};
      end else if (cfg_wr_i.wr) begin
         case (cfg_wr_i.addr)
            `DRGC_OFS_CW1:    cw1_r  <= cfg_wr_i.data;
            `DRGC_OFS_CW2:    cw2_r  <= cfg_wr_i.data;
            `DRGC_OFS_RISE:   rise_r <= cfg_wr_i.data;
            `DRGC_OFS_FALL:   fall_r <= cfg_wr_i.data;
            `DRGC_OFS_RATE:   rate_r <= cfg_wr_i.data;
            `DRGC_OFS_LIM_LO: lim_r[31:0]  <= cfg_wr_i.data;
            `DRGC_OFS_LIM_HI: lim_r[63:32] <= cfg_wr_i.data;
            default: ;                          // Unmapped writes dropped
         endcase
      end
   end

   // Decode shadow control bits
   always_comb begin
      ctl_nxt.en     = cw2_r[`DRGC_B_EN];
      ctl_nxt.ndh    = cw2_r[`DRGC_B_NDH];
      ctl_nxt.ndl    = cw2_r[`DRGC_B_NDL];
      ctl_nxt.dest   = cw2_r[`DRGC_B_DST_HI:`DRGC_B_DST_LO];
      ctl_nxt.flen   = cw2_r[`DRGC_B_FLEN];
      ctl_nxt.reload = cw1_r[`DRGC_B_RELOAD];
      ctl_nxt.clr    = cw1_r[`DRGC_B_CLR];
      ctl_nxt.aclr   = cw1_r[`DRGC_B_ACLR];
   end

   // Update copies shadow into the active set
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctl_a_r  <= '0;
         rise_a_r <= `DRGC_RST_WORD;
         fall_a_r <= `DRGC_RST_WORD;
         rate_a_r <= `DRGC_RST_WORD;
         lim_a_r  <= {`DRGC_RST_WORD, `DRGC_RST_WORD};
      end else if (io_update_i) begin
         ctl_a_r  <= ctl_nxt;
         rise_a_r <= rise_r;
         fall_a_r <= fall_r;
         rate_a_r <= rate_r;
         lim_a_r  <= lim_r;
      end
   end

   // Update events wait for the next DDS tick; a new one wins the clear
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ev_en_r   <= 1'b0;
         ev_aclr_r <= 1'b0;
         ev_rld_r  <= 1'b0;
      end else if (io_update_i) begin
         ev_en_r   <= ev_en_r | (ctl_nxt.en & ~ctl_a_r.en);
         ev_aclr_r <= ev_aclr_r | ctl_nxt.aclr;
         ev_rld_r  <= ev_rld_r | ctl_nxt.reload;
      end else if (tick_r) begin
         ev_en_r   <= 1'b0;
         ev_aclr_r <= 1'b0;
         ev_rld_r  <= 1'b0;
      end
   end

   assign lower     = lim_a_r[31:0];
   assign upper     = lim_a_r[63:32];
   assign normal    = ~ctl_a_r.ndh & ~ctl_a_r.ndl;
   assign dir_edge  = tick_r & (dir_s_r != dir_d_r);
   assign expire    = tick_r & ~hold_s_r & (timer_r <= 16'h0001);
   assign force_low = ctl_a_r.clr | (tick_r & ev_aclr_r)
                    | (tick_r & ev_en_r & ~dir_s_r);
   assign sum_up    = {1'b0, acc_r} + {1'b0, rise_a_r};
   assign sum_dn    = {1'b0, acc_r} - {1'b0, fall_a_r};

   // Direction level seen at the previous tick
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dir_d_r <= 1'b0;
      end else if (tick_r) begin
         dir_d_r <= dir_s_r;
      end
   end

   // Interval timer, counts DDS cycles while enabled
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         timer_r <= `DRGC_RST_TIMER;
      end else if (!ctl_a_r.en) begin
         timer_r <= timer_r;
      end else if (tick_r & (ev_en_r | dir_edge | ev_rld_r | expire)) begin
         timer_r <= dir_s_r ? rate_a_r[`DRGC_RATE_P_LO +: 16]
                            : rate_a_r[`DRGC_RATE_N_LO +: 16];
      end else if (tick_r & ~hold_s_r) begin
         timer_r <= timer_r - 16'h0001;
      end
   end

   // Accumulator with limit logic in its feedback path
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= `DRGC_RST_WORD;
      end else if (!ctl_a_r.en) begin
         acc_r <= acc_r;
      end else if (force_low) begin
         acc_r <= lower;
      end else if (expire & ~ev_en_r & ~dir_edge & dir_s_r) begin
         if (sum_up[32] | (sum_up[31:0] >= upper)) begin
            acc_r <= ctl_a_r.ndh ? lower : upper;
         end else begin
            acc_r <= sum_up[31:0];
         end
      end else if (expire & ~ev_en_r & ~dir_edge) begin
         if (sum_dn[32] | (sum_dn[31:0] <= lower)) begin
            acc_r <= ctl_a_r.ndl ? upper : lower;
         end else begin
            acc_r <= sum_dn[31:0];
         end
      end else if (acc_r > upper) begin
         acc_r <= upper;
      end else if (acc_r < lower) begin
         acc_r <= lower;
      end
   end

   // Output stage: word, routed word, flag, mode
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ramp_word_o           <= `DRGC_RST_WORD;
         dest_word_o           <= `DRGC_RST_WORD;
         dest_sel_o            <= 2'h0;
         ramp_limit_flag_pin_o <= 1'b0;
         normal_mode_o         <= 1'b1;
      end else begin
         ramp_word_o <= acc_r;
         dest_sel_o  <= ctl_a_r.dest;
         case (ctl_a_r.dest)
            drgc_pkg::DRGC_DST_FREQ:  dest_word_o <= acc_r;
            drgc_pkg::DRGC_DST_PHASE:
               dest_word_o <= {acc_r[31:16], 16'h0000};
            default: dest_word_o <= {acc_r[31:20], 20'h00000};
         endcase
         ramp_limit_flag_pin_o <= ctl_a_r.en & ctl_a_r.flen
                                & ((acc_r == lower) | (acc_r == upper));
         normal_mode_o <= normal;
      end
   end

   // Checks, on the default clock and reset declared above
   // Tick every 24 system cycles, none in between
   property p_dds_rate;
      tick_r |=> (!tick_r)[*8] ##1 (!tick_r)[*8] ##1 (!tick_r)[*7]
         ##1 tick_r;
   endproperty
   a_dds_rate: assert property (p_dds_rate)
      else $error("DDS tick spacing wrong");
   property p_bounds;
      ctl_a_r.en && $past(ctl_a_r.en) && $stable(lim_a_r) && lower < upper
      && normal |-> acc_r <= upper && acc_r >= lower;
   endproperty
   a_bounds: assert property (p_bounds)
      else $error("Accumulator outside limits");
   property p_clear;
      ctl_a_r.en && ctl_a_r.clr |=> acc_r == $past(lower);
   endproperty
   a_clear: assert property (p_clear)
      else $error("Clear did not force lower limit");
   property p_hold;
      ctl_a_r.en && hold_s_r && !force_low && !ev_en_r && !dir_edge
      && $stable(lim_a_r) && acc_r <= upper && acc_r >= lower
      |=> $stable(acc_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Accumulator moved during freeze");
   property p_reload;
      ctl_a_r.en && dir_edge |=> timer_r == ($past(dir_s_r)
         ? $past(rate_a_r[15:0]) : $past(rate_a_r[31:16]));
   endproperty
   a_reload: assert property (p_reload)
      else $error("Timer not reloaded on direction change");
   property p_rise_step;
      ctl_a_r.en && expire && dir_s_r && !force_low && !ev_en_r
      && !dir_edge && !sum_up[32] && sum_up[31:0] < upper
      |=> acc_r == $past(acc_r) + $past(rise_a_r);
   endproperty
   a_rise_step: assert property (p_rise_step)
      else $error("Rising step wrong");
   property p_fall_step;
      ctl_a_r.en && expire && !dir_s_r && !force_low && !ev_en_r
      && !dir_edge && !sum_dn[32] && sum_dn[31:0] > lower
      |=> acc_r == $past(acc_r) - $past(fall_a_r);
   endproperty
   a_fall_step: assert property (p_fall_step)
      else $error("Falling step wrong");
   property p_aclr;
      ctl_a_r.en && tick_r && ev_aclr_r && !io_update_i
      |=> acc_r == $past(lower) ##1 !ev_aclr_r;
   endproperty
   a_aclr: assert property (p_aclr)
      else $error("Auto-clear not a single cycle");
   property p_flag;
      ctl_a_r.en && ctl_a_r.flen && acc_r == upper && $stable(ctl_a_r)
      |=> ramp_limit_flag_pin_o;
   endproperty
   a_flag: assert property (p_flag)
      else $error("Limit flag missing at upper limit");
   property p_phase;
      ctl_a_r.dest == drgc_pkg::DRGC_DST_PHASE
      |=> dest_word_o == {$past(acc_r[31:16]), 16'h0000};
   endproperty
   a_phase: assert property (p_phase)
      else $error("Phase routing wrong");

   c_reach_upper: cover property (
      ctl_a_r.en && dir_s_r && acc_r == upper && upper != lower);
   c_freeze: cover property (ctl_a_r.en && hold_s_r && tick_r);
   c_clear: cover property (ctl_a_r.en && ctl_a_r.clr);
   c_autoclear: cover property (ctl_a_r.en && tick_r && ev_aclr_r);

endmodule : drgc_core

// file: testbench/drgc_host.sv
// Host model: register writes, updates and ramp pins
`timescale 1ns/1ns
`include "drgc_defines.svh"
module drgc_host (
   input  wire logic          ref_clk_i,
   output drgc_pkg::drgc_wr_t cfg_wr_o,
   output logic               io_update_o,
   output logic               dir_o,
   output logic               frz_o
);
   // Idle port and pins from time zero
   initial begin
      cfg_wr_o    = '0;
      io_update_o = 1'b0;
      dir_o       = 1'b0;
      frz_o       = 1'b0;
   end

   // One write; data inverted once the strobe drops
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      cfg_wr_o <= '{wr: 1'b1, addr: a, data: d};
      @(posedge ref_clk_i);
      cfg_wr_o <= '{wr: 1'b0, addr: ~a, data: ~d};
   endtask : wr

   // Step sizes always given as plain magnitudes
   task automatic steps(input logic [31:0] r, input logic [31:0] f);
      wr(`DRGC_OFS_RISE, r);
      wr(`DRGC_OFS_FALL, f);
   endtask : steps

   // Limit pair, only sent with upper above lower
   task automatic lims(input logic [31:0] l, input logic [31:0] h);
      if (h > l) begin
         wr(`DRGC_OFS_LIM_LO, l);
         wr(`DRGC_OFS_LIM_HI, h);
      end
   endtask : lims

   // One-cycle update pulse
   task automatic upd();
      @(posedge ref_clk_i);
      io_update_o <= 1'b1;
      @(posedge ref_clk_i);
      io_update_o <= 1'b0;
   endtask : upd

   // Direction and freeze levels
   task automatic pins(input logic d, input logic f);
      @(posedge ref_clk_i);
      dir_o <= d;
      frz_o <= f;
   endtask : pins
endmodule : drgc_host

// file: testbench/drgc_core_bench.sv
// Self-checking bench for the ramp generator core
`timescale 1ns/1ns
`include "drgc_defines.svh"
module drgc_core_bench;
   localparam logic [31:0] EN = 32'h1 << `DRGC_B_EN;   // Enable bit
   localparam logic [31:0] FL = 32'h1 << `DRGC_B_FLEN; // Flag enable
   logic               ref_clk_i; // System clock
   logic               rstn_i;    // Reset, active low
   drgc_pkg::drgc_wr_t cfg_wr;    // Write port
   logic               io_upd;    // Update pulse
   logic               dir_pin;   // Direction pin
   logic               frz_pin;   // Freeze pin
   logic [31:0]        ramp_word; // Ramp output
   logic [31:0]        dest_word; // Routed output
   logic [1:0]         dest_sel;  // Active destination
   logic               lim_flag;  // Limit flag
   logic               normal;    // Normal mode
   int                 failures   = 0;
   int                 n_compared = 0;
   int                 cyc        = 0;
   logic [31:0]        lo;        // Current lower limit
   logic [31:0]        v;         // Sampled ramp word
   int                 n;         // Cycles waited

   // 10 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   drgc_host HOST (
      .ref_clk_i   (ref_clk_i),
      .cfg_wr_o    (cfg_wr),
      .io_update_o (io_upd),
      .dir_o       (dir_pin),
      .frz_o       (frz_pin)
   );

   drgc_core DUT (
      .ref_clk_i             (ref_clk_i),
      .rstn_i                (rstn_i),
      .cfg_wr_i              (cfg_wr),
      .io_update_i           (io_upd),
      .ramp_direction_pin_i  (dir_pin),
      .ramp_freeze_pin_i     (frz_pin),
      .ramp_word_o           (ramp_word),
      .dest_word_o           (dest_word),
      .dest_sel_o            (dest_sel),
      .ramp_limit_flag_pin_o (lim_flag),
      .normal_mode_o         (normal)
   );

   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Wait for the ramp word to move, counting cycles
   task automatic wait_chg(output int c);
      logic [31:0] w;
      w = ramp_word;
      c = 0;
      do begin
         @(negedge ref_clk_i);
         c++;
      end while (ramp_word === w && c < 4000);
   endtask : wait_chg

   // Wait for a given ramp word, then compare
   task automatic wait_val(input logic [31:0] e);
      int c;
      c = 0;
      while (ramp_word !== e && c < 4000) begin
         @(negedge ref_clk_i);
         c++;
      end
      chk(ramp_word, e);
   endtask : wait_val

   // Enable at update with direction low settles at lower limit
   task automatic t_enable;
      @(negedge ref_clk_i);
      chk(ramp_word, 32'h0);
      chk({31'h0, normal}, 32'h1);
      lo = 32'h10;
      HOST.steps(32'h5, 32'h3);
      HOST.wr(`DRGC_OFS_RATE, 32'h0001_0002);
      HOST.lims(lo, 32'h100);
      HOST.wr(8'h05, 32'hFFFF_FFFF);
      HOST.wr(`DRGC_OFS_CW2, EN | FL);
      HOST.upd();
      wait_val(lo);
      chk({31'h0, lim_flag}, 32'h1);
      $display("enable test done");
   endtask : t_enable

   // Rising slope, stop at upper, resume when upper raised
   task automatic t_rise;
      HOST.pins(1'b1, 1'b0);
      wait_chg(n);
      v = ramp_word;
      wait_chg(n);
      chk(n, 32'h30);
      chk(ramp_word, v + 32'h5);
      wait_val(32'h100);
      repeat (60) @(negedge ref_clk_i);
      chk(ramp_word, 32'h100);
      chk({31'h0, lim_flag}, 32'h1);
      HOST.lims(lo, 32'h200);
      HOST.upd();
      wait_chg(n);
      chk(ramp_word, 32'h105);
      chk({31'h0, n < 52}, 32'h1);
      $display("rise test done");
   endtask : t_rise

   // Falling slope, stop at lower, resume when lower dropped
   task automatic t_fall;
      HOST.pins(1'b0, 1'b0);
      wait_chg(n);
      v = ramp_word;
      wait_chg(n);
      chk(n, 32'h18);
      chk(ramp_word, v - 32'h3);
      wait_val(lo);
      lo = 32'h8;
      HOST.lims(lo, 32'h200);
      HOST.upd();
      wait_chg(n);
      chk(ramp_word, 32'hD);
      $display("fall test done");
   endtask : t_fall

   // Freeze pin stall, then reload of the timer at update
   task automatic t_freeze;
      HOST.pins(1'b1, 1'b0);
      wait_chg(n);
      HOST.pins(1'b1, 1'b1);
      repeat (5) @(negedge ref_clk_i);
      v = ramp_word;
      repeat (150) @(negedge ref_clk_i);
      chk(ramp_word, v);
      HOST.pins(1'b1, 1'b0);
      wait_chg(n);
      chk(ramp_word, v + 32'h5);
      HOST.wr(`DRGC_OFS_RATE, 32'h0001_0040);
      HOST.wr(`DRGC_OFS_CW1, 32'h1 << `DRGC_B_RELOAD);
      HOST.upd();
      wait_chg(n);
      chk({31'h0, n > 1530 && n < 1590}, 32'h1);
      HOST.wr(`DRGC_OFS_RATE, 32'h0001_0002);
      HOST.upd();
      $display("freeze test done");
   endtask : t_freeze

   // Clear held until update, then single auto-clear
   task automatic t_clear;
      HOST.wr(`DRGC_OFS_CW1, 32'h1 << `DRGC_B_CLR);
      HOST.upd();
      repeat (3) @(negedge ref_clk_i);
      chk(ramp_word, lo);
      repeat (100) @(negedge ref_clk_i);
      chk(ramp_word, lo);
      HOST.wr(`DRGC_OFS_CW1, 32'h0);
      HOST.upd();
      wait_chg(n);
      chk(ramp_word, lo + 32'h5);
      HOST.wr(`DRGC_OFS_CW1, 32'h1 << `DRGC_B_ACLR);
      HOST.upd();
      wait_val(lo);
      wait_chg(n);
      chk(ramp_word, lo + 32'h5);
      HOST.wr(`DRGC_OFS_CW1, 32'h0);
      HOST.upd();
      $display("clear test done");
   endtask : t_clear

   // Routed word for every destination code
   task automatic t_dest;
      lo = 32'hABCD_1234;
      HOST.lims(lo, 32'hFFFF_FFF0);
      HOST.wr(`DRGC_OFS_CW1, 32'h1 << `DRGC_B_CLR);
      for (int d = 0; d < 4; d++) begin
         HOST.wr(`DRGC_OFS_CW2, EN | FL | (32'(d) << `DRGC_B_DST_LO));
         HOST.upd();
         repeat (4) @(negedge ref_clk_i);
         v = (d == 0) ? lo : lo & ((d == 1) ? 32'hFFFF_0000 : 32'hFFF0_0000);
         chk(dest_word, v);
         chk({30'h0, dest_sel}, 32'(d));
      end
      $display("destination test done");
   endtask : t_dest

   // No-dwell bits leave normal mode; enable clear freezes
   task automatic t_mode;
      for (int b = 0; b < 2; b++) begin
         HOST.wr(`DRGC_OFS_CW2, EN | (32'h1 << (`DRGC_B_NDL + b)));
         HOST.upd();
         repeat (3) @(negedge ref_clk_i);
         chk({31'h0, normal}, 32'h0);
      end
      HOST.wr(`DRGC_OFS_CW2, FL);
      HOST.lims(32'h20, 32'hFFFF_FFF0);
      HOST.upd();
      repeat (60) @(negedge ref_clk_i);
      chk(ramp_word, lo);
      chk({31'h0, lim_flag}, 32'h0);
      chk({31'h0, normal}, 32'h1);
      $display("mode test done");
   endtask : t_mode

   // Counts and verdict, then stop
   task automatic finish_test;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   // Hang guard
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         $display("Error at %0t: timeout", $time);
         finish_test;
      end
   end

   // Main sequence
   initial begin
      rstn_i = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      t_enable;
      t_rise;
      t_fall;
      t_freeze;
      t_clear;
      t_dest;
      t_mode;
      finish_test;
   end
endmodule : drgc_core_bench
